// >>> shared/tcmc_pkg.sv
// Package of constants and types for the timer channel mode control block
package tcmc_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 32;
    // Register offsets (word aligned byte addresses)
    localparam logic [3:0]  OFS_CTL_LOW    = 4'h0;
    localparam logic [3:0]  OFS_CMP_VALUE  = 4'h4;
    localparam logic [3:0]  OFS_CMP_ACTIVE = 4'h8;
    localparam logic [3:0]  OFS_STATUS     = 4'hC;
    // Field positions of channel_pair_control_low
    localparam int          MS0_LSB        = 0;
    localparam int          FEN0_BIT       = 2;
    localparam int          SEN0_BIT       = 3;
    localparam int          PSC0_LSB       = 2;
    localparam int          FLT0_LSB       = 4;
    localparam int          MS1_LSB        = 8;
    localparam int          PSC1_LSB       = 10;
    localparam int          FLT1_LSB       = 12;
    localparam int          CTL_USED_W     = 16;
    // Reset values
    localparam logic [15:0] CTL_RESET      = 16'h0000;
    localparam logic [15:0] CMP_RESET      = 16'h0000;
    // Codes
    localparam logic [1:0]  MS_OUTPUT      = 2'h0;
    localparam logic [1:0]  MS_IN_CH0      = 2'h1;
    localparam logic [1:0]  MS_IN_CH1      = 2'h2;
    localparam logic [1:0]  MS_IN_TRIG     = 2'h3;
    localparam logic [1:0]  PROTECTION_LEVEL_LOCKED    = 2'h3;
    localparam logic [2:0]  CMP_PWM0       = 3'h6;
    localparam logic [2:0]  CMP_PWM1       = 3'h7;
    // Filter sample counter width
    localparam int          FCNT_W         = 4;
    typedef enum logic [1:0] {
        TCMC_IDLE, TCMC_HUNT
    } tcmc_filt_state_t;
endpackage

// >>> design/tcmc_filter.sv
// Digital input filter: validates a level after a run of equal samples
`timescale 1ns/1ns
`default_nettype none
module tcmc_filter (
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      sample_en,
    input  wire logic [3:0]                filter_code,
    input  wire logic                      raw_in,
    output logic                           filt_out
);
    import tcmc_pkg::*;

    logic [tcmc_pkg::FCNT_W-1:0] cnt_ff, nxt_cnt;
    logic                        last_ff, nxt_last;
    logic                        out_ff, nxt_out;
    logic [tcmc_pkg::FCNT_W-1:0] need;

    // Required run of equal samples for each filter code
    function automatic logic [3:0] run_len(input logic [3:0] code);
        unique case (code)
            4'h0: run_len = 4'h1;
            4'h1: run_len = 4'h2;
            4'h2: run_len = 4'h4;
            4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hF: run_len = 4'h8;
            4'hA, 4'hD: run_len = 4'h5;
            default: run_len = 4'h6;
        endcase
    endfunction

    assign need = run_len(filter_code);

    // Count equal samples, restart on any difference
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_last = last_ff;
        nxt_out  = out_ff;
        if (filter_code == 4'h0) begin
            nxt_out  = raw_in;
            nxt_last = raw_in;
            nxt_cnt  = '0;
        end else if (sample_en) begin
            nxt_last = raw_in;
            if (raw_in != last_ff) begin
                nxt_cnt = 4'h1;
            end else if (cnt_ff < need) begin
                nxt_cnt = cnt_ff + 4'h1;
            end
            if (raw_in == last_ff && cnt_ff + 4'h1 >= need) begin
                nxt_out = raw_in;
            end
        end
    end

    // Filter state registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_ff  <= '0;
            last_ff <= 1'b0;
            out_ff  <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            last_ff <= nxt_last;
            out_ff  <= nxt_out;
        end
    end

    assign filt_out = out_ff;
endmodule // tcmc_filter
`default_nettype wire

// >>> design/tcmc_channel_ctl.sv
// Channel pair mode control: register, shadowing, fast compare, inputs
//
// Behaviour
// - Shadow enable set: compare writes wait for update event, else immediate.
// - Shadow enable bit locked when protection is 11 and mode is 00.
// - Fast enable: trigger edge acts as compare match and raises the compare event.
// - Fast acceleration only in PWM mode 0 or 1.
// - Channel 0 mode field writable only while channel disabled.
// - Mode 00 output, 01 input0, 10 input1, 11 internal trigger.
// - Filter accepts level after configured count of equal samples.
// - Channel 1 filter field behaves like channel 0; the channel 1 divider field has no effect.
// - Divider captures every 1, 2, 4, 8 edges; reset on disable.
`timescale 1ns/1ns
`default_nettype none
module tcmc_channel_ctl (
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic [tcmc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tcmc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [tcmc_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        update_event,
    input  wire logic                        counter_match,
    input  wire logic                        ch0_enable_bit,
    input  wire logic [1:0]                  protection_level,
    input  wire logic                        single_pulse_flag,
    input  wire logic                        internal_trigger_signal,
    input  wire logic                        trigger_edge,
    input  wire logic [2:0]                  ch0_compare_mode,
    input  wire logic                        filter_sample_rate,
    input  wire logic                        ch0_input_raw,
    input  wire logic                        ch1_input_raw,
    output logic                             ch0_compare_event,
    output logic                             ch0_capture_event,
    output logic                             ch1_filtered,
    output logic                             pwm_shadow_warn
);
    import tcmc_pkg::*;

    logic [15:0] ctl_ff, nxt_ctl;
    logic [15:0] cmp_shadow_ff, nxt_cmp_shadow;
    logic [15:0] cmp_active_ff, nxt_cmp_active;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        cmp_ev_ff, nxt_cmp_ev;
    logic        cap_ev_ff, nxt_cap_ev;
    logic [2:0]  psc_cnt_ff, nxt_psc_cnt;
    logic        sel_last_ff, nxt_sel_last;
    logic        ch1f_ff, nxt_ch1f;
    logic        warn_ff, nxt_warn;
    logic        filt0, filt1, sel_in;
    logic        wr_ctl, is_pwm, cap_edge;

    // Filters for both channel inputs
    tcmc_filter u_filt0 (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .sample_en   (filter_sample_rate),
        .filter_code (ctl_ff[FLT0_LSB +: 4]),
        .raw_in      (ch0_input_raw),
        .filt_out    (filt0)
    );
    tcmc_filter u_filt1 (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .sample_en   (filter_sample_rate),
        .filter_code (ctl_ff[FLT1_LSB +: 4]),
        .raw_in      (ch1_input_raw),
        .filt_out    (filt1)
    );

    // Edge count mask (divisor minus one) for a divider code
    function automatic logic [2:0] div_mask(input logic [1:0] code);
        div_mask = 3'((4'h1 << code) - 4'h1);
    endfunction

    // Input source selection
    always_comb begin
        unique case (ctl_ff[MS0_LSB +: 2])
            MS_IN_CH0:  sel_in = filt0;
            MS_IN_CH1:  sel_in = filt1;
            MS_IN_TRIG: sel_in = internal_trigger_signal;
            MS_OUTPUT:  sel_in = 1'b0;
        endcase
    end

    assign wr_ctl   = reg_wr && reg_addr == OFS_CTL_LOW;
    assign is_pwm   = ch0_compare_mode == CMP_PWM0 ||
                      ch0_compare_mode == CMP_PWM1;
    assign cap_edge = ctl_ff[MS0_LSB +: 2] != MS_OUTPUT &&
                      ch0_enable_bit && sel_in && !sel_last_ff;

    // Control and compare next state
    // Bits 3:2 double as the divider field in capture view
    always_comb begin
        nxt_ctl        = ctl_ff;
        nxt_cmp_shadow = cmp_shadow_ff;
        nxt_cmp_active = cmp_active_ff;
        if (wr_ctl) begin
            nxt_ctl[15:4] = reg_wdata[15:4];
            nxt_ctl[FEN0_BIT] = reg_wdata[FEN0_BIT];
            if (!(protection_level == PROTECTION_LEVEL_LOCKED &&
                  ctl_ff[MS0_LSB +: 2] == MS_OUTPUT)) begin
                nxt_ctl[SEN0_BIT] = reg_wdata[SEN0_BIT];
            end
            if (!ch0_enable_bit) begin
                nxt_ctl[MS0_LSB +: 2] = reg_wdata[MS0_LSB +: 2];
            end
        end
        if (reg_wr && reg_addr == OFS_CMP_VALUE) begin
            nxt_cmp_shadow = reg_wdata[15:0];
            if (!ctl_ff[SEN0_BIT]) begin
                nxt_cmp_active = reg_wdata[15:0];
            end
        end
        if (update_event && ctl_ff[SEN0_BIT]) begin
            nxt_cmp_active = nxt_cmp_shadow;
        end
    end

    // Control and compare registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl_ff        <= CTL_RESET;
            cmp_shadow_ff <= CMP_RESET;
            cmp_active_ff <= CMP_RESET;
        end else begin
            ctl_ff        <= nxt_ctl;
            cmp_shadow_ff <= nxt_cmp_shadow;
            cmp_active_ff <= nxt_cmp_active;
        end
    end

    // Capture divider next state
    always_comb begin
        nxt_psc_cnt  = psc_cnt_ff;
        nxt_sel_last = sel_in;
        nxt_cap_ev   = 1'b0;
        if (!ch0_enable_bit) begin
            nxt_psc_cnt = '0;
        end else if (cap_edge) begin
            if ((psc_cnt_ff & div_mask(ctl_ff[PSC0_LSB +: 2])) ==
                div_mask(ctl_ff[PSC0_LSB +: 2])) begin
                nxt_psc_cnt = '0;
                nxt_cap_ev  = 1'b1;
            end else begin
                nxt_psc_cnt = psc_cnt_ff + 3'h1;
            end
        end
    end

    // Capture divider registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            psc_cnt_ff  <= '0;
            sel_last_ff <= 1'b0;
            cap_ev_ff   <= 1'b0;
        end else begin
            psc_cnt_ff  <= nxt_psc_cnt;
            sel_last_ff <= nxt_sel_last;
            cap_ev_ff   <= nxt_cap_ev;
        end
    end

    // Event and status next state
    always_comb begin
        nxt_ch1f   = filt1;
        // Fast trigger counts as a match only in PWM modes
        nxt_cmp_ev = counter_match;
        if (ctl_ff[FEN0_BIT] && is_pwm && trigger_edge) begin
            nxt_cmp_ev = 1'b1;
        end
        // Flag PWM without shadow outside single pulse use
        nxt_warn   = is_pwm && !ctl_ff[SEN0_BIT] &&
                     !single_pulse_flag;
    end

    // Event and status registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmp_ev_ff <= 1'b0;
            ch1f_ff   <= 1'b0;
            warn_ff   <= 1'b0;
        end else begin
            cmp_ev_ff <= nxt_cmp_ev;
            ch1f_ff   <= nxt_ch1f;
            warn_ff   <= nxt_warn;
        end
    end

    // Read data next state, zero outside the answer cycle
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTL_LOW:    nxt_rdata = {16'h0000, ctl_ff};
                OFS_CMP_VALUE:  nxt_rdata = {16'h0000, cmp_shadow_ff};
                OFS_CMP_ACTIVE: nxt_rdata = {16'h0000, cmp_active_ff};
                OFS_STATUS:     nxt_rdata = {27'h0, psc_cnt_ff,
                                             filt1, filt0};
                default:        nxt_rdata = '0;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata         = rdata_ff;
    assign ch0_compare_event = cmp_ev_ff;
    assign ch0_capture_event = cap_ev_ff;
    assign ch1_filtered      = ch1f_ff;
    assign pwm_shadow_warn   = warn_ff;
endmodule // tcmc_channel_ctl
`default_nettype wire

// >>> verification/tcmc_sva.sv
// Port checker for the channel pair mode control block
`timescale 1ns/1ns
`default_nettype none
module tcmc_sva (
    input wire logic                        ref_clk,
    input wire logic                        sys_rst,
    input wire logic                        reg_rd,
    input wire logic [tcmc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                        counter_match,
    input wire logic                        trigger_edge,
    input wire logic [2:0]                  ch0_compare_mode,
    input wire logic                        single_pulse_flag,
    input wire logic                        ch1_input_raw,
    input wire logic                        ch0_compare_event,
    input wire logic                        ch0_capture_event,
    input wire logic                        ch1_filtered,
    input wire logic                        pwm_shadow_warn
);
    import tcmc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // No compare cause at all this cycle
    sequence s_quiet;
        !counter_match && !trigger_edge;
    endsequence
    // Counter quiet while the mode is not PWM
    sequence s_nonpwm;
        !counter_match && (ch0_compare_mode < CMP_PWM0);
    endsequence
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not idle");
    AST_UPPER_ZERO: assert property (reg_rdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    AST_MATCH: assert property (counter_match |=>
        ch0_compare_event)
        else $error("match gave no compare event");
    AST_QUIET: assert property (s_quiet |=> !ch0_compare_event)
        else $error("compare event without cause");
    AST_NONPWM: assert property (s_nonpwm |=> !ch0_compare_event)
        else $error("fast compare outside PWM");
    AST_WARN_SPM: assert property (single_pulse_flag |=>
        !pwm_shadow_warn)
        else $error("warning in single pulse mode");
    AST_WARN_MODE: assert property (s_nonpwm |=> !pwm_shadow_warn)
        else $error("warning outside PWM");
    AST_CAP_PULSE: assert property (ch0_capture_event |=>
        !ch0_capture_event)
        else $error("capture event longer than a cycle");
    AST_FILT: assert property ($changed(ch1_filtered) |->
        ch1_filtered == $past(ch1_input_raw, 2) ||
        ch1_filtered == $past(ch1_input_raw, 3))
        else $error("filter output moved against input");
endmodule // tcmc_sva
bind tcmc_channel_ctl tcmc_sva u_sva (.ref_clk, .sys_rst, .reg_rd, .reg_rdata,
    .counter_match, .trigger_edge, .ch0_compare_mode, .single_pulse_flag,
    .ch1_input_raw, .ch0_compare_event, .ch0_capture_event, .ch1_filtered,
    .pwm_shadow_warn);
`default_nettype wire

// >>> verification/tb_timer_channel_mode_control.sv
// Testbench for the channel pair mode control block
`timescale 1ns/1ns
`default_nettype none
module tb_timer_channel_mode_control;
    import tcmc_pkg::*;
    logic        ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic        update_event = 0, counter_match = 0, ch0_enable_bit = 0;
    logic        single_pulse_flag = 0, internal_trigger_signal = 0;
    logic        trigger_edge = 0, filter_sample_rate = 1;
    logic        ch0_input_raw = 0, ch1_input_raw = 0;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [1:0]  protection_level = 0;
    logic [2:0]  ch0_compare_mode = 0;
    logic        ch0_compare_event, ch0_capture_event;
    logic        ch1_filtered, pwm_shadow_warn;
    int          fail_count = 0, n_tests = 0, caps = 0, c0;
    tcmc_channel_ctl dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .update_event, .counter_match, .ch0_enable_bit,
        .protection_level, .single_pulse_flag, .internal_trigger_signal,
        .trigger_edge, .ch0_compare_mode, .filter_sample_rate, .ch0_input_raw,
        .ch1_input_raw, .ch0_compare_event, .ch0_capture_event, .ch1_filtered,
        .pwm_shadow_warn);
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    // Count capture pulses
    always @(posedge ref_clk) if (ch0_capture_event === 1'b1) caps <= caps + 1;
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk($sformatf("rdata at %h", a), e, reg_rdata);
    endtask
    task automatic results;
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #500000;
        fail_count++;
        results();
    end
    // Main sequence
    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        rd(OFS_CTL_LOW, 32'h0);
        rd(4'h2, 32'h0);
        wr(OFS_CMP_VALUE, 32'h1234);
        rd(OFS_CMP_ACTIVE, 32'h1234);
        wr(OFS_CTL_LOW, 32'h8);
        wr(OFS_CMP_VALUE, 32'hABCD);
        rd(OFS_CMP_ACTIVE, 32'h1234);
        @(posedge ref_clk) update_event <= 1'b1;
        @(posedge ref_clk) update_event <= 1'b0;
        rd(OFS_CMP_ACTIVE, 32'hABCD);
        protection_level <= PROTECTION_LEVEL_LOCKED;
        wr(OFS_CTL_LOW, 32'h0);
        rd(OFS_CTL_LOW, 32'h8);
        protection_level <= 2'h0;
        wr(OFS_CTL_LOW, 32'h0);
        rd(OFS_CTL_LOW, 32'h0);
        ch0_enable_bit <= 1'b1;
        wr(OFS_CTL_LOW, 32'h1);
        rd(OFS_CTL_LOW, 32'h0);
        ch0_enable_bit <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTL_LOW, m);
            rd(OFS_CTL_LOW, m);
        end
        // Trigger edge under every compare mode, fast bit set
        wr(OFS_CTL_LOW, 32'h4);
        for (int m = 0; m < 8; m++) begin
            ch0_compare_mode <= m[2:0];
            @(posedge ref_clk) trigger_edge <= 1'b1;
            @(posedge ref_clk) trigger_edge <= 1'b0;
            @(posedge ref_clk);
            chk("compare event", m >= 6, ch0_compare_event);
        end
        // Counter match alone gives a compare event
        @(posedge ref_clk) counter_match <= 1'b1;
        @(posedge ref_clk) counter_match <= 1'b0;
        @(posedge ref_clk);
        chk("compare event", 1, ch0_compare_event);
        wr(OFS_CTL_LOW, 32'h0);
        cyc(2);
        chk("shadow warn", 1, pwm_shadow_warn);
        single_pulse_flag <= 1'b1;
        cyc(2);
        chk("shadow warn", 0, pwm_shadow_warn);
        // Eight rising edges per source and divider code
        for (int s = 1; s < 4; s++) for (int d = 0; d < 4; d++) begin
            ch0_enable_bit <= 1'b0;
            wr(OFS_CTL_LOW, (d << 2) | s);
            ch0_enable_bit <= 1'b1;
            c0 = caps;
            repeat (8) begin
                {internal_trigger_signal, ch1_input_raw, ch0_input_raw} <=
                    3'(1 << (s - 1));
                cyc(4);
                {internal_trigger_signal, ch1_input_raw, ch0_input_raw} <= 3'h0;
                cyc(4);
            end
            cyc(4);
            chk("captures", 8 >> d, caps - c0);
        end
        // Channel 1 filter at eight samples: short runs rejected
        ch0_enable_bit <= 1'b0;
        wr(OFS_CTL_LOW, 32'h3000);
        ch1_input_raw <= 1'b1;
        cyc(7);
        ch1_input_raw <= 1'b0;
        cyc(2);
        ch1_input_raw <= 1'b1;
        cyc(7);
        ch1_input_raw <= 1'b0;
        cyc(12);
        chk("ch1 filtered", 0, ch1_filtered);
        ch1_input_raw <= 1'b1;
        cyc(12);
        chk("ch1 filtered", 1, ch1_filtered);
        rd(OFS_STATUS, 32'h2);
        results();
    end
endmodule // tb_timer_channel_mode_control
`default_nettype wire
